// >>> core/flash_cmd_params.svh
// Purpose: Constants for the flash erase and sleep command sequencer.
// Assumes: 100 MHz core clock.
// Notes:   Times are in nanoseconds; cycle counts derive from them.
`ifndef FLASH_CMD_PARAMS_SVH
`define FLASH_CMD_PARAMS_SVH
`define CLK_PERIOD_NS          10
`define SECTOR_CLEAR_TIME_NS   20000
`define ARRAY_CLEAR_TIME_NS    100000
`define SLEEP_ENTRY_DELAY_NS   3000
`define WAKE_DELAY_NS          30000
`define SECTOR_CLEAR_CYC       ((`SECTOR_CLEAR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ARRAY_CLEAR_CYC        ((`ARRAY_CLEAR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLEEP_ENTRY_CYC        ((`SLEEP_ENTRY_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_CYC               ((`WAKE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OPC_SECTOR_CLEAR       8'hD8
`define OPC_ARRAY_CLEAR        8'hC7
`define OPC_SLEEP_ENTRY        8'hB9
`define OPC_WAKE               8'hAB
`define OPC_WRITE_UNLOCK       8'h06
`define SECTOR_ADDR_HI         18
`define SECTOR_ADDR_LO         16
`define SECTOR_SEL_W           3
`define FRAME_BITS_OPC         6'd8
`define FRAME_BITS_ADDR        6'd32
`endif

// >>> core/flash_cmd_pkg.sv
// Purpose: Types for the flash erase and sleep command sequencer.
// Assumes: Nothing beyond the constants header.
// Notes:   Jobs carry what the timed engine needs.
`default_nettype none
package flash_cmd_pkg;
  typedef enum logic [1:0] {
    JOB_SECTOR,
    JOB_ARRAY,
    JOB_SLEEP,
    JOB_WAKE
  } job_kind_t;
  typedef struct packed {
    job_kind_t  kind;
    logic [2:0] sector;
  } job_t;
endpackage
`default_nettype wire

// >>> core/flash_cmd_seq.sv
// Purpose: Serial frame decoder and timed engine for sector erase, array erase,
//          deep sleep entry and wake commands inside a serial flash.
// Assumes: Link pins are asynchronous; SCK is sampled by MCLK_I, mode 0/3.
// Notes:   Erase effects are reported as pulses toward the array.
`default_nettype none
`include "flash_cmd_params.svh"
module flash_cmd_seq #(
  parameter logic [7:0] OPC_SECTOR  = `OPC_SECTOR_CLEAR,
  parameter logic [7:0] OPC_ARRAY   = `OPC_ARRAY_CLEAR,
  parameter logic [7:0] OPC_SLEEP   = `OPC_SLEEP_ENTRY,
  parameter logic [7:0] OPC_WAKE    = `OPC_WAKE,
  parameter logic [7:0] OPC_UNLOCK  = `OPC_WRITE_UNLOCK,
  parameter int         SECTOR_CYC  = `SECTOR_CLEAR_CYC,
  parameter int         ARRAY_CYC   = `ARRAY_CLEAR_CYC,
  parameter int         SLEEP_CYC   = `SLEEP_ENTRY_CYC,
  parameter int         WAKE_CYC    = `WAKE_CYC,
  parameter int         NUM_SECTORS = 8
) (
  input  wire logic                     MCLK_I,
  input  wire logic                     SRST_I,
  input  wire logic                     CS_N_I,
  input  wire logic                     SCK_I,
  input  wire logic                     SDI_I,
  input  wire logic                     RESET_N_I,
  input  wire logic [NUM_SECTORS-1:0]   HW_PROTECT_I,
  input  wire logic [NUM_SECTORS-1:0]   SW_PROTECT_I,
  input  wire logic                     OTHER_CYCLE_BUSY_I,
  output logic                          BUSY_FLAG_O,
  output logic                          WRITE_UNLOCK_LATCH_O,
  output logic                          DEEP_SLEEP_O,
  output logic                          STANDBY_O,
  output logic                          RESET_MODE_O,
  output logic                          LOCK_CLEAR_O,
  output logic                          SECTOR_CLEAR_O,
  output logic [`SECTOR_SEL_W-1:0]      SECTOR_SEL_O,
  output logic                          ARRAY_CLEAR_O
);
  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // The sector select is three bits wide, so exactly eight sectors are served,
  // and every delay must fit the shared 24-bit down-counter.
  localparam int TIMER_MAX = 24'hFF_FFFF;
  if (NUM_SECTORS != 8) begin : g_bad_sectors
    $error("flash_cmd_seq: NUM_SECTORS must be 8");
  end
  if (SECTOR_CYC < 1 || SECTOR_CYC > TIMER_MAX) begin : g_bad_sector_cyc
    $error("flash_cmd_seq: SECTOR_CYC out of range");
  end
  if (ARRAY_CYC < 1 || ARRAY_CYC > TIMER_MAX) begin : g_bad_array_cyc
    $error("flash_cmd_seq: ARRAY_CYC out of range");
  end
  if (SLEEP_CYC < 1 || SLEEP_CYC > TIMER_MAX) begin : g_bad_sleep_cyc
    $error("flash_cmd_seq: SLEEP_CYC out of range");
  end
  if (WAKE_CYC < 1 || WAKE_CYC > TIMER_MAX) begin : g_bad_wake_cyc
    $error("flash_cmd_seq: WAKE_CYC out of range");
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic       sck_prev_q;
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      meta_q     <= 4'h9;
      sync_q     <= 4'h9;
      sck_prev_q <= 1'b0;
    end else begin
      meta_q     <= {RESET_N_I, SDI_I, SCK_I, CS_N_I};
      sync_q     <= meta_q;
      sck_prev_q <= sync_q[1];
    end
  end
  logic cs_n;
  logic sck_rise;
  logic sdi;
  logic rst_pin_n;
  assign cs_n      = sync_q[0];
  assign sck_rise  = sync_q[1] & ~sck_prev_q;
  assign sdi       = sync_q[2];
  assign rst_pin_n = sync_q[3];

  logic cs_prev_q;
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      cs_prev_q <= 1'b1;
    end else begin
      cs_prev_q <= cs_n;
    end
  end
  logic cs_rise;
  assign cs_rise = cs_n & ~cs_prev_q;

  // ----------------------------------------------------------------------
  // Frame shifter
  // ----------------------------------------------------------------------
  // The counter saturates so that very long frames can never alias onto a
  // valid length.
  logic [5:0]  bits_q;
  logic [31:0] shift_q;
  always_ff @(posedge MCLK_I) begin
    if (SRST_I || cs_n || !rst_pin_n) begin
      bits_q <= 6'd0;
    end else if (sck_rise && bits_q != 6'd63) begin
      bits_q <= bits_q + 6'd1;
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      shift_q <= 32'h0000_0000;
    end else if (!cs_n && sck_rise) begin
      shift_q <= {shift_q[30:0], sdi};
    end
  end

  // ----------------------------------------------------------------------
  // Decode at deselect
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ENG_STANDBY,
    ENG_ERASE,
    ENG_SLEEP_WAIT,
    ENG_DEEP_SLEEP,
    ENG_WAKE_WAIT,
    ENG_RESET
  } state_t;
  state_t state_q;

  logic [7:0]                opc8;
  logic [7:0]                opc32;
  logic [`SECTOR_SEL_W-1:0]  sec_addr;
  logic                      len_opc;
  logic                      len_addr;
  logic                      engine_busy;
  logic                      sleeping;
  assign opc8        = shift_q[7:0];
  assign opc32       = shift_q[31:24];
  assign sec_addr    = shift_q[`SECTOR_ADDR_HI:`SECTOR_ADDR_LO];
  assign len_opc     = (bits_q == `FRAME_BITS_OPC);
  assign len_addr    = (bits_q == `FRAME_BITS_ADDR);
  assign engine_busy = (state_q == ENG_ERASE) || OTHER_CYCLE_BUSY_I;
  assign sleeping    = (state_q == ENG_DEEP_SLEEP);

  logic go_sector;
  logic go_array;
  logic go_sleep;
  logic go_wake;
  logic go_unlock;
  always_comb begin
    go_sector = 1'b0;
    go_array  = 1'b0;
    go_sleep  = 1'b0;
    go_wake   = 1'b0;
    go_unlock = 1'b0;
    if (cs_rise && rst_pin_n && !engine_busy && state_q != ENG_SLEEP_WAIT && state_q != ENG_WAKE_WAIT) begin
      if (sleeping) begin
        go_wake = len_opc && opc8 == OPC_WAKE;
      end else if (state_q == ENG_STANDBY) begin
        go_sector = len_addr && opc32 == OPC_SECTOR && WRITE_UNLOCK_LATCH_O
                    && !HW_PROTECT_I[sec_addr];
        go_array  = len_opc && opc8 == OPC_ARRAY && WRITE_UNLOCK_LATCH_O
                    && !(|HW_PROTECT_I) && !(|SW_PROTECT_I);
        go_sleep  = len_opc && opc8 == OPC_SLEEP;
        go_unlock = len_opc && opc8 == OPC_UNLOCK;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Timed engine
  // ----------------------------------------------------------------------
  // ----------------------------------------------------------------------
  // Job record
  // ----------------------------------------------------------------------
  // The accepted command and its sector travel together, so the sector clear
  // pulse and the sector select always describe the same job.
  flash_cmd_pkg::job_t job_q;
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      job_q <= '{kind: flash_cmd_pkg::JOB_SECTOR, sector: 3'b000};
    end else if (go_sector) begin
      job_q <= '{kind: flash_cmd_pkg::JOB_SECTOR, sector: sec_addr};
    end else if (go_array) begin
      job_q <= '{kind: flash_cmd_pkg::JOB_ARRAY, sector: 3'b000};
    end else if (go_sleep) begin
      job_q <= '{kind: flash_cmd_pkg::JOB_SLEEP, sector: 3'b000};
    end else if (go_wake) begin
      job_q <= '{kind: flash_cmd_pkg::JOB_WAKE, sector: 3'b000};
    end
  end

  // ----------------------------------------------------------------------
  // Timed engine
  // ----------------------------------------------------------------------
  // One down-counter serves every delay: only one timed phase can run at a
  // time, so a second counter would sit idle and only cost area.
  logic [23:0] timer_q;
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      state_q <= ENG_STANDBY;
      timer_q <= 24'h00_0000;
    end else if (!rst_pin_n) begin
      state_q <= ENG_RESET;
      timer_q <= 24'h00_0000;
    end else begin
      unique case (state_q)
        ENG_STANDBY: begin
          if (go_sector) begin
            state_q <= ENG_ERASE;
            timer_q <= 24'(SECTOR_CYC - 1);
          end else if (go_array) begin
            state_q <= ENG_ERASE;
            timer_q <= 24'(ARRAY_CYC - 1);
          end else if (go_sleep) begin
            state_q <= ENG_SLEEP_WAIT;
            timer_q <= 24'(SLEEP_CYC - 1);
          end
        end
        ENG_ERASE, ENG_SLEEP_WAIT, ENG_WAKE_WAIT: begin
          if (timer_q != 24'h00_0000) begin
            timer_q <= timer_q - 24'h00_0001;
          end else if (state_q == ENG_SLEEP_WAIT) begin
            state_q <= ENG_DEEP_SLEEP;
          end else begin
            state_q <= ENG_STANDBY;
          end
        end
        ENG_DEEP_SLEEP: begin
          if (go_wake) begin
            state_q <= ENG_WAKE_WAIT;
            timer_q <= 24'(WAKE_CYC - 1);
          end
        end
        ENG_RESET: begin
          state_q <= ENG_STANDBY;
        end
        // Codes six and seven have no state; fall back to standby.
        default: begin
          state_q <= ENG_STANDBY;
          timer_q <= 24'h00_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------------
  // The latch drops when the erase starts, which lies before completion.
  always_ff @(posedge MCLK_I) begin
    if (SRST_I || !rst_pin_n) begin
      WRITE_UNLOCK_LATCH_O <= 1'b0;
    end else if (go_sector || go_array) begin
      WRITE_UNLOCK_LATCH_O <= 1'b0;
    end else if (go_unlock) begin
      WRITE_UNLOCK_LATCH_O <= 1'b1;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      BUSY_FLAG_O <= 1'b0;
    end else begin
      BUSY_FLAG_O <= rst_pin_n && (go_sector || go_array ||
                     (state_q == ENG_ERASE && timer_q != 24'h00_0000));
    end
  end

  // The wake delay still counts as deep sleep: the host may not select the
  // device again until it has passed.
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      DEEP_SLEEP_O <= 1'b0;
      STANDBY_O    <= 1'b1;
    end else begin
      DEEP_SLEEP_O <= rst_pin_n && (state_q == ENG_DEEP_SLEEP || state_q == ENG_WAKE_WAIT);
      STANDBY_O    <= rst_pin_n && state_q == ENG_STANDBY && cs_n && !go_sector
                      && !go_array && !go_sleep;
    end
  end

  // ----------------------------------------------------------------------
  // Reset pin reporting
  // ----------------------------------------------------------------------
  // Both flags follow the synchronised pin, so they lag it by the two
  // synchroniser stages plus this register.
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      RESET_MODE_O <= 1'b0;
      LOCK_CLEAR_O <= 1'b0;
    end else begin
      RESET_MODE_O <= !rst_pin_n;
      LOCK_CLEAR_O <= !rst_pin_n;
    end
  end

  // ----------------------------------------------------------------------
  // Array pulses
  // ----------------------------------------------------------------------
  // Completion is reported as a one-cycle pulse; the array side does the
  // actual clearing to all ones. An aborted erase never reaches this point.
  logic erase_done;
  assign erase_done = rst_pin_n && state_q == ENG_ERASE && timer_q == 24'h00_0000;
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      SECTOR_CLEAR_O <= 1'b0;
      ARRAY_CLEAR_O  <= 1'b0;
    end else begin
      SECTOR_CLEAR_O <= erase_done && job_q.kind == flash_cmd_pkg::JOB_SECTOR;
      ARRAY_CLEAR_O  <= erase_done && job_q.kind == flash_cmd_pkg::JOB_ARRAY;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      SECTOR_SEL_O <= '0;
    end else if (job_q.kind == flash_cmd_pkg::JOB_SECTOR) begin
      SECTOR_SEL_O <= job_q.sector;
    end
  end
endmodule // flash_cmd_seq
`default_nettype wire

// >>> verification/spi_host_model.sv
// Purpose: Serial host that shifts command frames into the sequencer.
// Assumes: Mode 0 clocking, 16 core clocks per serial clock period.
// Notes:   The serial clock rests low and the data line toggles outside frames.
`default_nettype none
module spi_host_model (
  input  wire logic clk_i,
  output var  logic cs_n_o,
  output var  logic sck_o,
  output var  logic sdi_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    sdi_o  = 1'b0;
  end
  // A deselected data line must never look steady, so it flips every cycle.
  always @(posedge clk_i) begin
    if (cs_n_o) sdi_o <= #1 ~sdi_o;
  end
  task automatic hc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  // Bits leave from the top of w; any bits past 32 are zero.
  task automatic send(input int n, input logic [31:0] w);
    logic [31:0] s;
    s = w;
    cs_n_o = 1'b0;
    hc(8);
    for (int i = 0; i < n; i++) begin
      sdi_o = s[31];
      s = s << 1;
      hc(8);
      sck_o = 1'b1;
      hc(8);
      sck_o = 1'b0;
    end
    hc(8);
    cs_n_o = 1'b1;
  endtask
endmodule // spi_host_model
`default_nettype wire

// >>> verification/flash_cmd_seq_props.sv
// Purpose: Concurrent checks on the erase and sleep sequencer ports.
// Assumes: Erase times well above eight cycles and below a thousand.
// Notes:   Bound into every instance of the sequencer.
`default_nettype none
`include "flash_cmd_params.svh"
module flash_cmd_seq_props #(
  parameter int NUM_SECTORS = 8
) (
  input wire logic                   MCLK_I,
  input wire logic                   SRST_I,
  input wire logic                   RESET_N_I,
  input wire logic [NUM_SECTORS-1:0] HW_PROTECT_I,
  input wire logic [NUM_SECTORS-1:0] SW_PROTECT_I,
  input wire logic                   BUSY_FLAG_O,
  input wire logic                   WRITE_UNLOCK_LATCH_O,
  input wire logic                   DEEP_SLEEP_O,
  input wire logic                   RESET_MODE_O,
  input wire logic                   LOCK_CLEAR_O,
  input wire logic                   SECTOR_CLEAR_O,
  input wire logic [`SECTOR_SEL_W-1:0] SECTOR_SEL_O,
  input wire logic                   ARRAY_CLEAR_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (SRST_I);
  sequence s_start;
    $rose(BUSY_FLAG_O);
  endsequence
  // The pin passes a two-stage synchroniser, hence the margin of five.
  sequence s_pin_low;
    !RESET_N_I [*5];
  endsequence
  a_latch_before_erase: assert property (s_start |-> $past(WRITE_UNLOCK_LATCH_O))
    else $error("erase began without the unlock latch");
  a_latch_cleared: assert property (s_start |-> !WRITE_UNLOCK_LATCH_O)
    else $error("unlock latch kept during erase");
  a_busy_bounded: assert property (s_start |-> BUSY_FLAG_O [*8] ##[1:1000] !BUSY_FLAG_O)
    else $error("busy flag length wrong");
  a_pulse_ends_busy: assert property ((SECTOR_CLEAR_O || ARRAY_CLEAR_O) |-> !BUSY_FLAG_O && $past(BUSY_FLAG_O))
    else $error("erase pulse not at busy end");
  a_pulse_single: assert property ((SECTOR_CLEAR_O || ARRAY_CLEAR_O) |=> !SECTOR_CLEAR_O && !ARRAY_CLEAR_O)
    else $error("erase pulse longer than one cycle");
  a_sector_unprotected: assert property (SECTOR_CLEAR_O |-> !HW_PROTECT_I[SECTOR_SEL_O])
    else $error("protected sector erased");
  a_array_unprotected: assert property (ARRAY_CLEAR_O |-> (HW_PROTECT_I | SW_PROTECT_I) == '0)
    else $error("array erased while protected");
  a_sleep_no_erase: assert property (DEEP_SLEEP_O |-> !BUSY_FLAG_O)
    else $error("erase running in deep sleep");
  a_reset_aborts: assert property (s_pin_low |-> RESET_MODE_O && LOCK_CLEAR_O && !BUSY_FLAG_O)
    else $error("reset pin did not abort");
endmodule // flash_cmd_seq_props
bind flash_cmd_seq flash_cmd_seq_props #(.NUM_SECTORS(NUM_SECTORS)) u_props (.MCLK_I, .SRST_I, .RESET_N_I,
  .HW_PROTECT_I, .SW_PROTECT_I, .BUSY_FLAG_O, .WRITE_UNLOCK_LATCH_O, .DEEP_SLEEP_O, .RESET_MODE_O,
  .LOCK_CLEAR_O, .SECTOR_CLEAR_O, .SECTOR_SEL_O, .ARRAY_CLEAR_O);
`default_nettype wire

// >>> verification/flash_cmd_seq_tb.sv
// Purpose: Self-checking bench for the erase and sleep sequencer.
// Assumes: Default opcodes; shortened cycle counts set below.
// Notes:   Erase pulses are matched against a queue of expected notes.
`default_nettype none
`include "flash_cmd_params.svh"
module flash_cmd_seq_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SC = 400;
  localparam int AC = 600;
  localparam int DC = 20;
  localparam int WC = 30;
  logic       mclk = 1'b0;
  logic       srst = 1'b1;
  logic       rst_n = 1'b1;
  logic       oth = 1'b0;
  logic [7:0] hwp = 8'h00;
  logic [7:0] swp = 8'h00;
  logic [4:0] exp_q[$];
  logic [23:0] a;
  int         seed;
  int         error_cnt = 0;
  int         check_count = 0;
  wire logic  cs_n, sck, sdi, busy, write_unlock_latch, deep, stby, rmode, lock, sclr, aclr;
  wire logic [2:0] ssel;
  always #5 mclk = ~mclk;
  spi_host_model host (.clk_i(mclk), .cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi));
  flash_cmd_seq #(.SECTOR_CYC(SC), .ARRAY_CYC(AC), .SLEEP_CYC(DC), .WAKE_CYC(WC)) uut (
    .MCLK_I(mclk), .SRST_I(srst), .CS_N_I(cs_n), .SCK_I(sck), .SDI_I(sdi), .RESET_N_I(rst_n),
    .HW_PROTECT_I(hwp), .SW_PROTECT_I(swp), .OTHER_CYCLE_BUSY_I(oth), .BUSY_FLAG_O(busy),
    .WRITE_UNLOCK_LATCH_O(write_unlock_latch), .DEEP_SLEEP_O(deep), .STANDBY_O(stby), .RESET_MODE_O(rmode),
    .LOCK_CLEAR_O(lock), .SECTOR_CLEAR_O(sclr), .SECTOR_SEL_O(ssel), .ARRAY_CLEAR_O(aclr));
  task automatic chk_bit(input string s, input logic e, input logic v);
    check_count++;
    if (v !== e) begin
      error_cnt++;
      $display("BAD %s expected %b seen %b", s, e, v);
    end
  endtask
  task automatic chk_pulse(input logic [4:0] v);
    logic [4:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 5'h1f;
    check_count++;
    if (v !== e) begin
      error_cnt++;
      $display("BAD erase pulse expected %h seen %h", e, v);
    end
  endtask
  // Every erase pulse must match the oldest note, and none may come unasked.
  always @(negedge mclk) begin
    if ((sclr | aclr) === 1'b1) chk_pulse({aclr, sclr, sclr ? ssel : 3'b000});
  end
  task automatic wt(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic cmd(input int n, input logic [31:0] w);
    host.send(n, w);
    wt(8);
  endtask
  task automatic unlock();
    cmd(8, {`OPC_WRITE_UNLOCK, 24'h0000_00});
  endtask
  task automatic serase(input logic [23:0] x, input bit ok);
    cmd(32, {`OPC_SECTOR_CLEAR, x});
    if (ok) exp_q.push_back({2'b01, x[18:16]});
    wt(SC + 20);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    // About twelve thousand cycles are needed; this leaves ample margin.
    #300_000;
    error_cnt++;
    stop_test();
  end
  initial begin
    seed = 31239;
    wt(20);
    srst = 1'b0;
    wt(6);
    chk_bit("standby", 1'b1, stby);
    for (int i = 0; i < 3; i++) begin
      a = 24'($random(seed));
      unlock();
      chk_bit("latch", 1'b1, write_unlock_latch);
      serase(a, 1'b1);
    end
    serase(24'($random(seed)), 1'b0);
    unlock();
    cmd(31, {`OPC_SECTOR_CLEAR, 24'h0000_00});
    cmd(33, {`OPC_SECTOR_CLEAR, 24'h0000_00});
    chk_bit("busy", 1'b0, busy);
    hwp = 8'h01 << a[18:16];
    serase(a, 1'b0);
    hwp = 8'h00;
    swp = 8'h01 << ($unsigned($random(seed)) % 8);
    cmd(8, {`OPC_ARRAY_CLEAR, 24'h0000_00});
    chk_bit("busy", 1'b0, busy);
    swp = 8'h00;
    cmd(8, {`OPC_ARRAY_CLEAR, 24'h0000_00});
    exp_q.push_back(5'h10);
    wt(AC + 20);
    $display("test erase done");
    unlock();
    cmd(32, {`OPC_SECTOR_CLEAR, 24'h0200_00});
    exp_q.push_back(5'h0a);
    cmd(8, {`OPC_SLEEP_ENTRY, 24'h0000_00});
    wt(DC + 10);
    chk_bit("busy", 1'b1, busy);
    chk_bit("sleep", 1'b0, deep);
    wt(SC);
    unlock();
    oth = 1'b1;
    serase(24'h0100_00, 1'b0);
    oth = 1'b0;
    serase(24'h0100_00, 1'b1);
    $display("test refuse done");
    cmd(8, {`OPC_SLEEP_ENTRY, 24'h0000_00});
    wt(DC + 10);
    chk_bit("sleep", 1'b1, deep);
    unlock();
    chk_bit("latch", 1'b0, write_unlock_latch);
    cmd(9, {`OPC_WAKE, 24'h0000_00});
    wt(WC + 10);
    chk_bit("sleep", 1'b1, deep);
    cmd(8, {`OPC_WAKE, 24'h0000_00});
    wt(WC + 10);
    chk_bit("sleep", 1'b0, deep);
    chk_bit("standby", 1'b1, stby);
    $display("test sleep done");
    unlock();
    cmd(8, {`OPC_ARRAY_CLEAR, 24'h0000_00});
    wt(50);
    rst_n = 1'b0;
    wt(10);
    chk_bit("reset mode", 1'b1, rmode);
    chk_bit("lock clear", 1'b1, lock);
    chk_bit("busy", 1'b0, busy);
    rst_n = 1'b1;
    wt(AC + 20);
    chk_bit("latch", 1'b0, write_unlock_latch);
    chk_bit("queue empty", 1'b1, exp_q.size() == 0);
    $display("test reset done");
    stop_test();
  end
endmodule // flash_cmd_seq_tb
`default_nettype wire
